// File: rtl/mce_defs.svh
`ifndef MCE_DEFS_SVH
`define MCE_DEFS_SVH
// What this block does
// - Fetch side fills a two-word staging buffer, store side empties it, repeating to zero.
// - Copies only between internal memory locations; the block has no external pins.
// - Addresses are 32-bit word addresses in the normal word space only.
// - Writing one to control bit 1 flushes the buffer and resets both pointers.
// - Enable starts and stops the copy; toggling it leaves buffer contents alone.
// - When both sides want the internal bus, the fetch side goes first; the store side takes over once the buffer is full.
// - Fetch and store accesses share one internal data bus; each pair is two fetches followed by two stores.
// - Each side signals done after its whole block has been moved.
// - Only the store-side done event raises the interrupt request, gated by the mask bit.
// - Each 64-bit pair takes twelve clock cycles to copy.
// - A control write's enable and flush bits take effect two clock cycles after it completes; the mask bit takes effect at once.
// - Reading the control register shows whether fetch and store sides are active.
// - All logic runs on the peripheral clock.

// Register byte offsets
`define MCE_OFS_CTRL     12'h000
`define MCE_OFS_SRC_IDX  12'h004
`define MCE_OFS_SRC_MOD  12'h008
`define MCE_OFS_SRC_CNT  12'h00c
`define MCE_OFS_DST_IDX  12'h010
`define MCE_OFS_DST_MOD  12'h014
`define MCE_OFS_DST_CNT  12'h018
// Control register fields
`define MCE_BIT_EN       0
`define MCE_BIT_FLUSH    1
`define MCE_BIT_IRQMSK   2
`define MCE_BIT_RDACT    8
`define MCE_BIT_WRACT    9
`define MCE_BIT_RDDONE   10
`define MCE_BIT_WRDONE   11
// Timing
`define MCE_PAIR_NS      120
`define MCE_CLK_NS       10
`define MCE_PAIR_CYC     (`MCE_PAIR_NS / `MCE_CLK_NS)
`define MCE_LAT_CYC      2
`endif

// File: rtl/mce_pkg.sv
package mce_pkg;
  typedef enum logic [1:0] {MCE_IDLE, MCE_FETCH, MCE_STORE} mce_ch_type;
endpackage

// File: rtl/mce_fifo.sv
`include "mce_defs.svh"
// Two-entry staging buffer; flush clears pointers, not data
module mce_fifo
  import mce_pkg::*;
#(
  parameter int WIDTH = 32
)(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic                  wp;
    logic                  rp;
    logic [1:0]            cnt;
  } mce_fifo_type;

  mce_fifo_type s_q, s_d;

  assign in_ready  = (s_q.cnt != 2'h2);
  assign out_valid = (s_q.cnt != 2'h0);
  assign out_data  = s_q.mem[s_q.rp];

  // Push and pop may happen in one cycle; flush overrides both
  always_comb
  begin
    s_d = s_q;
    if (flush)
    begin
      s_d.wp  = 1'b0;
      s_d.rp  = 1'b0;
      s_d.cnt = 2'h0;
    end
    else
    begin
      if (in_valid && in_ready)
      begin
        s_d.mem[s_q.wp] = in_data;
        s_d.wp          = ~s_q.wp;
      end
      if (out_valid && out_ready)
        s_d.rp = ~s_q.rp;
      s_d.cnt = s_q.cnt + {1'b0, (in_valid && in_ready)} - {1'b0, (out_valid && out_ready)};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  chk_no_overfill: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.cnt <= 2'h2) else $error("staging buffer overfilled");
  chk_flush_empties: assert property (@(posedge pclk) disable iff (!presetn)
    flush |=> (s_q.cnt == 2'h0 && s_q.wp == 1'b0 && s_q.rp == 1'b0))
    else $error("flush left entries");
endmodule

// File: rtl/mce_top.sv
// The APB slave port and the register addresses were decided locally.
`include "mce_defs.svh"
// Memory copy engine: APB registers, fetch/store sequencer on one shared memory bus
module mce_top
  import mce_pkg::*;
#(
  parameter int AW = 32
)(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  output logic               mem_req,
  output logic               mem_we,
  output logic [AW-1:0]      mem_addr,
  output logic [31:0]        mem_wdata,
  input  wire logic [31:0]   mem_rdata,
  output logic               copy_irq
);
  typedef struct packed {
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          en_req;
    logic          flush_req;
    logic [1:0]    lat;
    logic          en;
    logic          irq_mask;
    logic [AW-1:0] src_idx;
    logic [AW-1:0] src_mod;
    logic [15:0]   src_cnt;
    logic [AW-1:0] dst_idx;
    logic [AW-1:0] dst_mod;
    logic [15:0]   dst_cnt;
    mce_ch_type    ch;
    logic [3:0]    slot;
    logic          rd_done;
    logic          wr_done;
    logic          mem_req;
    logic          mem_we;
    logic [AW-1:0] mem_addr;
    logic [31:0]   mem_wdata;
    logic          irq;
  } mce_state_type;

  mce_state_type s_q, s_d;

  logic        f_in_ready;
  logic        f_out_valid;
  logic [31:0] f_out_data;
  logic        f_push;
  logic        f_pop;
  logic        flush_now;
  logic        acc;
  logic        wr_acc;
  logic        rd_acc;

  // Word-aligned decode shared by read and write paths
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    mapped = hit(a, `MCE_OFS_CTRL) || hit(a, `MCE_OFS_SRC_IDX) || hit(a, `MCE_OFS_SRC_MOD)
          || hit(a, `MCE_OFS_SRC_CNT) || hit(a, `MCE_OFS_DST_IDX) || hit(a, `MCE_OFS_DST_MOD)
          || hit(a, `MCE_OFS_DST_CNT);
  endfunction

  assign acc    = psel && penable && !s_q.pready;
  assign wr_acc = acc && pwrite && mapped(paddr);
  assign rd_acc = acc && !pwrite;

  // Flush is applied when the delayed control write lands
  assign flush_now = (s_q.lat == 2'h1) && s_q.flush_req;
  // A fetch read returns data in its request cycle; it is pushed at the edge that ends it
  assign f_push = s_q.mem_req && !s_q.mem_we;
  assign f_pop  = s_q.mem_req && s_q.mem_we;

  mce_fifo #(.WIDTH(32)) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .flush     (flush_now),
    .in_valid  (f_push),
    .in_ready  (f_in_ready),
    .in_data   (mem_rdata),
    .out_valid (f_out_valid),
    .out_ready (f_pop),
    .out_data  (f_out_data)
  );

  // All state: APB slave, control latency pipe, copy sequencer
  always_comb
  begin
    s_d         = s_q;
    s_d.pready  = acc;
    s_d.pslverr = acc && !mapped(paddr);
    s_d.mem_req = 1'b0;
    s_d.mem_we  = 1'b0;
    s_d.irq     = 1'b0;
    if (rd_acc)
    begin
      s_d.prdata = 32'h0;
      if (hit(paddr, `MCE_OFS_CTRL))
      begin
        s_d.prdata[`MCE_BIT_EN]     = s_q.en;
        s_d.prdata[`MCE_BIT_IRQMSK] = s_q.irq_mask;
        s_d.prdata[`MCE_BIT_RDACT]  = s_q.en && (s_q.src_cnt != 16'h0);
        s_d.prdata[`MCE_BIT_WRACT]  = s_q.en && (s_q.dst_cnt != 16'h0);
        s_d.prdata[`MCE_BIT_RDDONE] = s_q.rd_done;
        s_d.prdata[`MCE_BIT_WRDONE] = s_q.wr_done;
      end
      else if (hit(paddr, `MCE_OFS_SRC_IDX)) s_d.prdata = s_q.src_idx;
      else if (hit(paddr, `MCE_OFS_SRC_MOD)) s_d.prdata = s_q.src_mod;
      else if (hit(paddr, `MCE_OFS_SRC_CNT)) s_d.prdata = {16'h0, s_q.src_cnt};
      else if (hit(paddr, `MCE_OFS_DST_IDX)) s_d.prdata = s_q.dst_idx;
      else if (hit(paddr, `MCE_OFS_DST_MOD)) s_d.prdata = s_q.dst_mod;
      else if (hit(paddr, `MCE_OFS_DST_CNT)) s_d.prdata = {16'h0, s_q.dst_cnt};
    end
    // Enable and flush of a control write pass a two-cycle pipe before they act
    if (s_q.lat != 2'h0)
      s_d.lat = s_q.lat - 2'h1;
    if (s_q.lat == 2'h1)
    begin
      s_d.en = s_q.en_req;
      if (!s_q.en_req)
        s_d.ch = MCE_IDLE;
    end
    if (wr_acc)
    begin
      if (hit(paddr, `MCE_OFS_CTRL))
      begin
        s_d.en_req    = pwdata[`MCE_BIT_EN];
        s_d.flush_req = pwdata[`MCE_BIT_FLUSH];
        s_d.irq_mask  = pwdata[`MCE_BIT_IRQMSK];
        s_d.lat       = 2'(`MCE_LAT_CYC);
        if (pwdata[`MCE_BIT_EN])
        begin
          s_d.rd_done = 1'b0;
          s_d.wr_done = 1'b0;
        end
      end
      // Word addresses only; low two bits are forced clear
      if (hit(paddr, `MCE_OFS_SRC_IDX)) s_d.src_idx = {pwdata[AW-1:2], 2'b00};
      if (hit(paddr, `MCE_OFS_SRC_MOD)) s_d.src_mod = {pwdata[AW-1:2], 2'b00};
      if (hit(paddr, `MCE_OFS_SRC_CNT)) s_d.src_cnt = pwdata[15:0];
      if (hit(paddr, `MCE_OFS_DST_IDX)) s_d.dst_idx = {pwdata[AW-1:2], 2'b00};
      if (hit(paddr, `MCE_OFS_DST_MOD)) s_d.dst_mod = {pwdata[AW-1:2], 2'b00};
      if (hit(paddr, `MCE_OFS_DST_CNT)) s_d.dst_cnt = pwdata[15:0];
    end
    // Pair slot timer paces one 64-bit pair per twelve cycles
    if (s_q.en)
    begin
      if (s_q.slot == 4'(`MCE_PAIR_CYC - 1))
        s_d.slot = 4'h0;
      else
        s_d.slot = s_q.slot + 4'h1;
      case (s_q.ch)
        MCE_IDLE:
        begin
          if (s_q.slot == 4'h0)
            s_d.ch = MCE_FETCH;
        end
        MCE_FETCH:
        begin
          // Store side takes over once it has work and the buffer is full; at most one access every other cycle
          if (f_out_valid && s_q.dst_cnt != 16'h0 && !f_in_ready)
            s_d.ch = MCE_STORE;
          else if (s_q.src_cnt != 16'h0 && f_in_ready && !s_q.mem_req && s_q.slot[0])
          begin
            s_d.mem_req  = 1'b1;
            s_d.mem_addr = s_q.src_idx;
            s_d.src_idx  = s_q.src_idx + s_q.src_mod;
            s_d.src_cnt  = s_q.src_cnt - 16'h1;
            if (s_q.src_cnt == 16'h1)
              s_d.rd_done = 1'b1;
          end
          else if (s_q.src_cnt == 16'h0 && f_out_valid)
            s_d.ch = MCE_STORE;
        end
        MCE_STORE:
        begin
          if (f_out_valid && s_q.dst_cnt != 16'h0 && !s_q.mem_req && s_q.slot[0])
          begin
            s_d.mem_req   = 1'b1;
            s_d.mem_we    = 1'b1;
            s_d.mem_addr  = s_q.dst_idx;
            s_d.mem_wdata = f_out_data;
            s_d.dst_idx   = s_q.dst_idx + s_q.dst_mod;
            s_d.dst_cnt   = s_q.dst_cnt - 16'h1;
            if (s_q.dst_cnt == 16'h1)
            begin
              s_d.wr_done = 1'b1;
              s_d.irq     = s_q.irq_mask;
            end
          end
          else if (!f_out_valid && !s_q.mem_req)
            s_d.ch = MCE_IDLE;
        end
        default:
          s_d.ch = MCE_IDLE;
      endcase
    end
  end

  // Single clock domain, peripheral clock only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q    <= '0;
      s_q.ch <= MCE_IDLE;
    end
    else
      s_q <= s_d;
  end

  assign prdata    = s_q.prdata;
  assign pready    = s_q.pready;
  assign pslverr   = s_q.pslverr;
  assign mem_req   = s_q.mem_req;
  assign mem_we    = s_q.mem_we;
  assign mem_addr  = s_q.mem_addr;
  assign mem_wdata = s_q.mem_wdata;
  assign copy_irq  = s_q.irq;

  chk_ctrl_latency: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && hit(paddr, `MCE_OFS_CTRL)) |=> ##1 (s_d.en == $past(pwdata[`MCE_BIT_EN], 2)))
    else $error("control write latency wrong");
  chk_no_empty_store: assert property (@(posedge pclk) disable iff (!presetn)
    (s_d.mem_req && s_d.mem_we) |-> f_out_valid) else $error("store from empty buffer");
  chk_no_full_fetch: assert property (@(posedge pclk) disable iff (!presetn)
    (s_d.mem_req && !s_d.mem_we) |-> f_in_ready) else $error("fetch into full buffer");
  chk_bus_alternate: assert property (@(posedge pclk) disable iff (!presetn)
    mem_req |=> !mem_req) else $error("back to back bus access");
  chk_src_step: assert property (@(posedge pclk) disable iff (!presetn)
    (s_d.mem_req && !s_d.mem_we) |=> s_q.src_cnt == $past(s_q.src_cnt) - 16'h1)
    else $error("fetch count not decremented");
  chk_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
    copy_irq |-> s_q.irq_mask && s_q.wr_done) else $error("irq without mask or done");
  chk_irq_single: assert property (@(posedge pclk) disable iff (!presetn)
    copy_irq |=> !copy_irq) else $error("irq longer than one pulse");
  chk_store_prio: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.ch == MCE_FETCH && !f_in_ready && s_q.dst_cnt != 16'h0 && s_q.en && s_q.lat != 2'h1)
      |=> s_q.ch == MCE_STORE) else $error("store side not preferred");
  chk_enable_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.lat == 2'h1 && !s_q.flush_req) |-> !flush_now) else $error("enable change flushed");
  chk_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> pready) else $error("apb answer late");
endmodule

// File: dv/mce_mem_model.sv
// On-chip memory behind the shared internal data bus
module mce_mem_model
(
  input  wire logic        pclk,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic      [31:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [256];
  logic [31:0] junk_q = 32'h0000_0000;
  // Engine pushes fetch data at the edge that ends its request cycle, so the read path is combinational
  assign mem_rdata = (mem_req && !mem_we) ? mem[mem_addr[7:0]] : junk_q;
  // Idle bus toggles so stale data never looks valid
  always @(posedge pclk)
  begin
    junk_q <= ~junk_q;
    if (mem_req && mem_we)
      mem[mem_addr[7:0]] <= mem_wdata;
  end
endmodule

// File: dv/mce_top_test.sv
`include "mce_defs.svh"
module mce_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, mem_addr, mem_wdata, mem_rdata, rd;
  logic        pready, pslverr, mem_req, mem_we, copy_irq, er, last_req = 0;
  int          miscompares = 0, tests_run = 0, fetches = 0, stores = 0, irqs = 0;
  time         first_req = 0, irq_t = 0, t0 = 0, t1 = 0;

  always #5 pclk = ~pclk;

  mce_top mce_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .copy_irq(copy_irq));
  mce_mem_model mce_mem_model_inst (.pclk(pclk), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task give_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Bus cycle: setup, access held until pready is sampled high
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    t0 = $time;
    psel <= 0;
    penable <= 0;
    // Idle edge so the next call never reassigns psel in this time step
    @(posedge pclk);
  endtask

  // Memory traffic tally; buffer level must stay within empty and two words
  always @(posedge pclk)
  begin
    if (mem_req === 1'b1)
    begin
      if (first_req == 0)
        first_req = $time;
      if (mem_we) stores++; else fetches++;
      if (fetches - stores > 2 || stores > fetches || last_req)
        chk(32'(fetches - stores), 32'h0000_0002);
    end
    last_req = mem_req;
    if (copy_irq === 1'b1)
    begin
      irqs++;
      irq_t = $time;
    end
  end

  task regs_check();
    for (int i = 0; i < 7; i++)
    begin
      bus(0, 12'(4 * i), 0, rd, er);
      chk(rd, 32'h0000_0000);
    end
    bus(1, `MCE_OFS_SRC_IDX, 32'h0000_0123, rd, er);
    bus(0, `MCE_OFS_SRC_IDX, 0, rd, er);
    chk(rd, 32'h0000_0120);
    bus(1, 12'h01c, 32'hffff_ffff, rd, er);
    chk(32'(er), 32'h0000_0001);
    bus(0, 12'h01c, 0, rd, er);
    chk(rd, 32'h0000_0000);
    bus(0, `MCE_OFS_CTRL, 0, rd, er);
    chk(rd, 32'h0000_0000);
  endtask

  // Program both sides, then flush before any enable
  task setup(input logic [31:0] n);
    bus(1, `MCE_OFS_SRC_IDX, 32'h0000_0000, rd, er);
    bus(1, `MCE_OFS_SRC_MOD, 32'h0000_0004, rd, er);
    bus(1, `MCE_OFS_SRC_CNT, n, rd, er);
    bus(1, `MCE_OFS_DST_IDX, 32'h0000_0080, rd, er);
    bus(1, `MCE_OFS_DST_MOD, 32'h0000_0004, rd, er);
    bus(1, `MCE_OFS_DST_CNT, n, rd, er);
    bus(1, `MCE_OFS_CTRL, 32'h0000_0002, rd, er);
    fetches = 0;
    stores = 0;
    irqs = 0;
    first_req = 0;
  endtask

  task copy_run();
    int n;
    n = 0;
    for (int i = 0; i < 4; i++)
    begin
      mce_mem_model_inst.mem[4 * i] = 32'hc0de_0000 + i;
      mce_mem_model_inst.mem[8'h80 + 4 * i] = 32'h0000_0000;
    end
    setup(4);
    bus(1, `MCE_OFS_CTRL, 32'h0000_0005, rd, er);
    t1 = t0;
    bus(0, `MCE_OFS_CTRL, 0, rd, er);
    chk(32'(|rd[9:8]), 32'h0000_0001);
    while (irqs == 0 && n < 100)
    begin
      @(posedge pclk);
      n++;
    end
    repeat (4) @(posedge pclk);
    chk(irqs, 1);
    chk(32'(first_req >= t1 + 20 && first_req <= t1 + 60), 32'h0000_0001);
    chk(32'(irq_t - first_req >= 120 && irq_t - first_req <= 250), 32'h0000_0001);
    chk(fetches, 4);
    chk(stores, 4);
    for (int i = 0; i < 4; i++)
      chk(mce_mem_model_inst.mem[8'h80 + 4 * i], 32'hc0de_0000 + i);
    bus(0, `MCE_OFS_CTRL, 0, rd, er);
    chk(32'(rd[11:8]), 32'h0000_000c);
    bus(1, `MCE_OFS_CTRL, 32'h0000_0002, rd, er);
  endtask

  // Stop mid-block with flush, interrupt left masked; traffic must cease and the irq tally stays zero
  task stop_run();
    int n;
    setup(16);
    bus(1, `MCE_OFS_CTRL, 32'h0000_0001, rd, er);
    repeat (20) @(posedge pclk);
    bus(1, `MCE_OFS_CTRL, 32'h0000_0002, rd, er);
    repeat (3) @(posedge pclk);
    n = fetches + stores;
    chk(32'(n > 0), 32'h0000_0001);
    repeat (30) @(posedge pclk);
    chk(fetches + stores, n);
    chk(irqs, 0);
  endtask

  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    regs_check();
    copy_run();
    stop_run();
    give_verdict();
  end

  // Whole run is a few hundred cycles; this cuts a hang short
  initial
  begin
    #100000;
    miscompares++;
    give_verdict();
  end
endmodule
